// File: core/ibuf_pkg.sv
// Package with register map, pointer widths and carrier structs for the shared buffer
package ibuf_pkg;
    localparam int PTR_W = 5;
    localparam int DATA_W = 8;
    localparam int DEPTH = 32;
    localparam logic [4:0] PTR_LAST = 5'h1f;
    localparam logic [4:0] PTR_RST = 5'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ADDR_BUS_CP = 8'hcc;
    localparam logic [7:0] ADDR_LOC_BP = 8'hcd;
    localparam logic [7:0] ADDR_LOC_CP = 8'hce;
    localparam logic [7:0] ADDR_WINDOW = 8'hcf;
    localparam int FIFO_DEPTH = 8;

    // Byte-level events from the bus protocol engine
    typedef struct packed {
        logic start;
        logic base_load;
        logic [4:0] base;
        logic wr_byte;
        logic rd_byte;
        logic [7:0] wdata;
    } ibuf_bus_ev_t;

    // Local register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ibuf_cpu_req_t;
endpackage : ibuf_pkg

// File: core/ibuf_fifo.sv
// Parameterised valid/ready FIFO built from flip-flops
`timescale 1ns/1ns
module ibuf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    // Ready is registered from the next fill level so the fill side sees a flop
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule : ibuf_fifo

// File: core/ibuf_ram.sv
// Dual-access 32x8 buffer storage with independent bus and local ports
`timescale 1ns/1ns
module ibuf_ram #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk,
    // Bus-side port
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_wdata,
    output logic [DW-1:0] a_rdata,
    // Local-side port
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DW-1:0] b_wdata,
    output logic [DW-1:0] b_rdata
);
    logic [DW-1:0] mem [DEPTH];

    // Unwritten entries have no reset, contents are undefined until written
    assign a_rdata = mem[a_addr];
    assign b_rdata = mem[b_addr];

    // Per-entry write; local side wins a same-cycle collision
    genvar gi;
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
        always_ff @(posedge clk) begin
            if (b_we && b_addr == AW'(gi)) begin
                mem[gi] <= b_wdata;
            end else if (a_we && a_addr == AW'(gi)) begin
                mem[gi] <= a_wdata;
            end
        end
    end
endmodule : ibuf_ram

// File: core/ibuf_top.sv
// Shared I2C slave data buffer with bus-side and local-side pointer pairs
`timescale 1ns/1ns
// Behaviour
// - Bus current pointer loads with the bus base pointer, same value, same time.
// - Bus current pointer steps by one after each completed data byte.
// - Bus current pointer saturates at 31, never wraps.
// - Bus reads and writes use the entry at the bus current pointer.
// - Every start condition reloads bus current pointer from bus base pointer.
// - Local base pointer changes only by local register writes; firmware sets it.
// - Writing local base pointer also loads the local current pointer.
// - Local current pointer wraps from 31 to zero.
// - Each window read or write advances the local current pointer.
// - Window read returns the byte at the local current pointer.
// - Window write stores the byte at the local current pointer.
// - Never-written entries read undefined.
// - Bus current pointer is read-only to the local side.
// - First master-write byte sets the bus base pointer; later bytes fill buffer.
// - Bus base pointer changes only at start of a master write.
module ibuf_top #(
    parameter int FIFO_DEPTH = ibuf_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus protocol engine events
    input wire ibuf_pkg::ibuf_bus_ev_t bus_ev,
    output logic bus_ev_ready,
    output logic [7:0] bus_rdata,
    output logic [4:0] bus_base,
    // Local register port
    input wire ibuf_pkg::ibuf_cpu_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid
);
    localparam int AW = ibuf_pkg::PTR_W;
    localparam int DW = ibuf_pkg::DATA_W;

    logic [4:0] bus_bp;
    logic [4:0] bus_cp;
    logic [4:0] loc_bp;
    logic [4:0] loc_cp;
    logic [DW-1:0] ram_a_rdata;
    logic [DW-1:0] ram_b_rdata;
    logic fifo_valid;
    logic [DW-1:0] fifo_data;
    logic ram_a_we;
    logic win_wr;
    logic win_rd;
    logic loc_bp_wr;
    logic cp_adv;
    logic start_seen;

    // Local register decode
    assign win_wr = cpu_req.wr && cpu_req.addr == ibuf_pkg::ADDR_WINDOW;
    assign win_rd = cpu_req.rd && cpu_req.addr == ibuf_pkg::ADDR_WINDOW;
    assign loc_bp_wr = cpu_req.wr && cpu_req.addr == ibuf_pkg::ADDR_LOC_BP;

    // Master write bytes queue through the FIFO; nothing holds a start until it drains, so
    // queued bytes can land at the reloaded pointer instead of the one they were addressed to
    ibuf_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(bus_ev.wr_byte),
        .in_ready(bus_ev_ready),
        .in_data(bus_ev.wdata),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );

    assign ram_a_we = fifo_valid;
    assign cp_adv = fifo_valid || bus_ev.rd_byte;

    // One storage array, each side through its own pointer pair
    ibuf_ram #(.DEPTH(ibuf_pkg::DEPTH), .AW(AW), .DW(DW)) u_ram (
        .clk(clk),
        .a_we(ram_a_we),
        .a_addr(bus_cp),
        .a_wdata(fifo_data),
        .a_rdata(ram_a_rdata),
        .b_we(win_wr),
        .b_addr(loc_cp),
        .b_wdata(cpu_req.wdata),
        .b_rdata(ram_b_rdata)
    );

    // Bus base pointer, only at the head of a master write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_bp <= ibuf_pkg::PTR_RST;
        end else if (bus_ev.base_load) begin
            bus_bp <= bus_ev.base;
        end
    end

    // Bus current pointer: reload beats advance
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_cp <= ibuf_pkg::PTR_RST;
        end else if (bus_ev.base_load) begin
            bus_cp <= bus_ev.base;
        end else if (bus_ev.start) begin
            bus_cp <= bus_bp;
        end else if (cp_adv && bus_cp != ibuf_pkg::PTR_LAST) begin
            bus_cp <= bus_cp + 5'h01;
        end
    end

    // Read data to the protocol engine, registered
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_rdata <= ibuf_pkg::DATA_RST;
            bus_base <= ibuf_pkg::PTR_RST;
        end else begin
            bus_rdata <= ram_a_rdata;
            bus_base <= bus_bp;
        end
    end

    // Local base pointer, written only by firmware
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            loc_bp <= ibuf_pkg::PTR_RST;
        end else if (loc_bp_wr) begin
            loc_bp <= cpu_req.wdata[4:0];
        end
    end

    // Local current pointer wraps naturally on five bits
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            loc_cp <= ibuf_pkg::PTR_RST;
        end else if (loc_bp_wr) begin
            loc_cp <= cpu_req.wdata[4:0];
        end else if (win_wr || win_rd) begin
            loc_cp <= loc_cp + 5'h01;
        end
    end

    // Register read mux; writes to read-only pointers are dropped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cpu_rdata <= ibuf_pkg::DATA_RST;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= cpu_req.rd;
            case (cpu_req.addr)
                ibuf_pkg::ADDR_BUS_CP: cpu_rdata <= {3'h0, bus_cp};
                ibuf_pkg::ADDR_LOC_BP: cpu_rdata <= {3'h0, loc_bp};
                ibuf_pkg::ADDR_LOC_CP: cpu_rdata <= {3'h0, loc_cp};
                ibuf_pkg::ADDR_WINDOW: cpu_rdata <= ram_b_rdata;
                default: cpu_rdata <= 8'h00;
            endcase
        end
    end

    // Helper for start-to-reload check
    assign start_seen = bus_ev.start && !bus_ev.base_load;

    // Shadow of the last window write, for the write-then-read check
    logic shadow_vld;
    logic [4:0] shadow_addr;
    logic [7:0] shadow_data;

    // A bus write to the shadowed entry spoils it; a same-cycle local write wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shadow_vld <= 1'b0;
            shadow_addr <= ibuf_pkg::PTR_RST;
            shadow_data <= ibuf_pkg::DATA_RST;
        end else if (win_wr) begin
            shadow_vld <= 1'b1;
            shadow_addr <= loc_cp;
            shadow_data <= cpu_req.wdata;
        end else if (ram_a_we && bus_cp == shadow_addr) begin
            shadow_vld <= 1'b0;
        end
    end

    // Assertions
    AST_CP_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        bus_ev.base_load |=> bus_cp == $past(bus_ev.base))
        else $error("bus current pointer did not load with base");
    AST_CP_INC: assert property (@(posedge clk) disable iff (!rst_b)
        (cp_adv && !bus_ev.base_load && !bus_ev.start && bus_cp != 5'h1f)
        |=> bus_cp == $past(bus_cp) + 5'h01)
        else $error("bus current pointer did not advance");
    AST_CP_SAT: assert property (@(posedge clk) disable iff (!rst_b)
        (bus_cp == 5'h1f && !bus_ev.base_load && !bus_ev.start) |=> bus_cp == 5'h1f)
        else $error("bus current pointer left 31");
    AST_CP_START: assert property (@(posedge clk) disable iff (!rst_b)
        start_seen |=> bus_cp == $past(bus_bp))
        else $error("start did not reload bus current pointer");
    AST_BP_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !bus_ev.base_load |=> $stable(bus_bp))
        else $error("bus base pointer changed outside a write head");
    AST_LBP_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !loc_bp_wr |=> $stable(loc_bp))
        else $error("local base pointer changed without a write");
    AST_LCP_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        loc_bp_wr |=> loc_cp == $past(cpu_req.wdata[4:0]))
        else $error("local current pointer not loaded with base");
    AST_LCP_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
        ((win_rd || win_wr) && !loc_bp_wr && loc_cp == 5'h1f) |=> loc_cp == 5'h00)
        else $error("local current pointer did not wrap");
    AST_LCP_INC: assert property (@(posedge clk) disable iff (!rst_b)
        ((win_rd || win_wr) && !loc_bp_wr) |=> loc_cp == $past(loc_cp) + 5'h01)
        else $error("window access did not advance pointer");
    AST_WIN_RD: assert property (@(posedge clk) disable iff (!rst_b)
        win_rd |=> cpu_rdata == $past(ram_b_rdata) && cpu_rvalid)
        else $error("window read returned wrong byte");
    AST_WIN_WR: assert property (@(posedge clk) disable iff (!rst_b)
        (win_rd && !win_wr && shadow_vld && loc_cp == shadow_addr)
        |=> cpu_rdata == $past(shadow_data))
        else $error("window write not stored at pointer");
    AST_CP_RO: assert property (@(posedge clk) disable iff (!rst_b)
        (cpu_req.wr && cpu_req.addr == 8'hcc && !cp_adv && !bus_ev.base_load && !bus_ev.start)
        |=> $stable(bus_cp))
        else $error("local write changed bus current pointer");

    COV_START: cover property (@(posedge clk) disable iff (!rst_b) start_seen);
    COV_SAT: cover property (@(posedge clk) disable iff (!rst_b) bus_cp == 5'h1f && cp_adv);
    COV_WRAP: cover property (@(posedge clk) disable iff (!rst_b) loc_cp == 5'h1f && win_rd);
    COV_FILL_DRAIN: cover property (@(posedge clk) disable iff (!rst_b)
        fifo_valid && bus_ev.wr_byte);
endmodule : ibuf_top

// File: tb/ibuf_bus_master_model.sv
// Behavioural bus protocol engine that feeds byte events into the buffer
`timescale 1ns/1ns
module ibuf_bus_master_model (
    // Clock
    input wire logic clk,
    // Event channel
    output ibuf_pkg::ibuf_bus_ev_t bus_ev,
    input wire logic bus_ev_ready,
    input wire logic [7:0] bus_rdata
);
    // Quiet channel until the first transaction
    initial begin
        bus_ev = '0;
    end

    // Start or repeated start, one cycle pulse
    task automatic start_cond();
        @(posedge clk);
        #1 bus_ev.start = 1'b1;
        @(posedge clk);
        #1 bus_ev.start = 1'b0;
    endtask : start_cond

    // Master write: base byte first, then data bytes offered at ready, or after 50 cycles of waiting without it
    task automatic write_txn(input logic [4:0] base, input int n, input logic [7:0] d [4]);
        int w;
        @(posedge clk);
        #1 bus_ev.base_load = 1'b1;
        bus_ev.base = base;
        @(posedge clk);
        #1 bus_ev.base_load = 1'b0;
        bus_ev.base = ~base; // Released lines show no stale value
        for (int i = 0; i < n; i++) begin
            w = 0;
            // Strobe dropped only while the FIFO refuses bytes
            while (bus_ev_ready !== 1'b1 && w < 50) begin
                bus_ev.wr_byte = 1'b0;
                @(posedge clk);
                #1 w++;
            end
            bus_ev.wr_byte = 1'b1;
            bus_ev.wdata = d[i];
            @(posedge clk);
            #1;
        end
        bus_ev.wr_byte = 1'b0;
        bus_ev.wdata = ~bus_ev.wdata;
        // Let the FIFO drain before any later start
        repeat (3) @(posedge clk);
        #1;
    endtask : write_txn

    // Master read: take the presented byte, then signal completion
    task automatic read_byte(output logic [7:0] d);
        @(posedge clk);
        #1 d = bus_rdata;
        bus_ev.rd_byte = 1'b1;
        @(posedge clk);
        #1 bus_ev.rd_byte = 1'b0;
    endtask : read_byte
endmodule : ibuf_bus_master_model

// File: tb/tb_ibuf_top.sv
// Self-checking testbench for the shared buffer pointer block
`timescale 1ns/1ns
module tb_ibuf_top;
    logic clk;
    logic rst_b;
    ibuf_pkg::ibuf_bus_ev_t bus_ev;
    ibuf_pkg::ibuf_cpu_req_t cpu_req;
    logic bus_ev_ready;
    logic [7:0] bus_rdata;
    logic [4:0] bus_base;
    logic [7:0] cpu_rdata;
    logic cpu_rvalid;
    int miscompares;
    int cmp_count;
    logic [7:0] v;
    logic [7:0] d [4];

    ibuf_top #(.FIFO_DEPTH(8)) dut_u (
        .clk(clk), .rst_b(rst_b), .bus_ev(bus_ev), .bus_ev_ready(bus_ev_ready),
        .bus_rdata(bus_rdata), .bus_base(bus_base), .cpu_req(cpu_req),
        .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid));
    ibuf_bus_master_model bm_u (
        .clk(clk), .bus_ev(bus_ev), .bus_ev_ready(bus_ev_ready), .bus_rdata(bus_rdata));

    // Clock source
    always #4 clk = ~clk;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Local register write, one cycle strobe
    task automatic cpu_wr(input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk);
        #1 cpu_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
        @(posedge clk);
        #1 cpu_req.wr = 1'b0;
        cpu_req.wdata = ~wd;
    endtask : cpu_wr

    // Local register read; data and valid stand for the cycle after the strobe
    task automatic cpu_rd(input logic [7:0] a, output logic [7:0] rd);
        @(posedge clk);
        #1 cpu_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 cpu_req.rd = 1'b0;
        rd = cpu_rdata;
        chk("rvalid", 8'h01, {7'h00, cpu_rvalid});
    endtask : cpu_rd

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        cpu_rd(a, r);
        chk(what, exp, r);
    endtask : rd_chk

    task automatic test_reset();
        chk("bus_base", 8'h00, {3'h0, bus_base});
        chk("ready", 8'h01, {7'h00, bus_ev_ready});
        rd_chk("bus cp", ibuf_pkg::ADDR_BUS_CP, 8'h00);
        rd_chk("loc bp", ibuf_pkg::ADDR_LOC_BP, 8'h00);
        rd_chk("loc cp", ibuf_pkg::ADDR_LOC_CP, 8'h00);
        rd_chk("unmapped", 8'hd0, 8'h00);
        $display("test reset done");
    endtask : test_reset

    // Window writes across the top entry, then read back from the same base
    task automatic test_local();
        cpu_wr(ibuf_pkg::ADDR_LOC_BP, 8'h1e);
        rd_chk("loc cp", ibuf_pkg::ADDR_LOC_CP, 8'h1e);
        cpu_wr(ibuf_pkg::ADDR_WINDOW, 8'h5a);
        cpu_wr(ibuf_pkg::ADDR_WINDOW, 8'ha5);
        cpu_wr(ibuf_pkg::ADDR_WINDOW, 8'h3c);
        rd_chk("loc cp", ibuf_pkg::ADDR_LOC_CP, 8'h01);
        cpu_wr(ibuf_pkg::ADDR_LOC_CP, 8'h09);
        rd_chk("loc cp ro", ibuf_pkg::ADDR_LOC_CP, 8'h01);
        cpu_wr(ibuf_pkg::ADDR_LOC_BP, 8'h1e);
        rd_chk("win 30", ibuf_pkg::ADDR_WINDOW, 8'h5a);
        rd_chk("win 31", ibuf_pkg::ADDR_WINDOW, 8'ha5);
        rd_chk("win 0", ibuf_pkg::ADDR_WINDOW, 8'h3c);
        rd_chk("loc cp", ibuf_pkg::ADDR_LOC_CP, 8'h01);
        $display("test local done");
    endtask : test_local

    // Master write running past the top entry; only written entries are read
    task automatic test_bus_write();
        d = '{8'h11, 8'h22, 8'h33, 8'h44};
        bm_u.write_txn(5'h1d, 4, d);
        chk("bus_base", 8'h1d, {3'h0, bus_base});
        chk("ready", 8'h01, {7'h00, bus_ev_ready});
        rd_chk("bus cp", ibuf_pkg::ADDR_BUS_CP, 8'h1f);
        cpu_wr(ibuf_pkg::ADDR_BUS_CP, 8'h00);
        rd_chk("bus cp ro", ibuf_pkg::ADDR_BUS_CP, 8'h1f);
        cpu_wr(ibuf_pkg::ADDR_LOC_BP, 8'h1d);
        rd_chk("buf 29", ibuf_pkg::ADDR_WINDOW, 8'h11);
        rd_chk("buf 30", ibuf_pkg::ADDR_WINDOW, 8'h22);
        rd_chk("buf 31", ibuf_pkg::ADDR_WINDOW, 8'h44);
        $display("test bus write done");
    endtask : test_bus_write

    // Firmware fills entries, master reads them after a start
    task automatic test_bus_read();
        cpu_wr(ibuf_pkg::ADDR_LOC_BP, 8'h02);
        cpu_wr(ibuf_pkg::ADDR_WINDOW, 8'hc1);
        cpu_wr(ibuf_pkg::ADDR_WINDOW, 8'hc2);
        cpu_wr(ibuf_pkg::ADDR_WINDOW, 8'hc3);
        bm_u.write_txn(5'h02, 0, d);
        rd_chk("bus cp", ibuf_pkg::ADDR_BUS_CP, 8'h02);
        bm_u.start_cond();
        for (int i = 0; i < 3; i++) begin
            bm_u.read_byte(v);
            chk("bus rd", 8'hc1 + 8'(i), v);
        end
        rd_chk("bus cp", ibuf_pkg::ADDR_BUS_CP, 8'h05);
        bm_u.start_cond();
        rd_chk("bus cp", ibuf_pkg::ADDR_BUS_CP, 8'h02);
        chk("bus_base", 8'h02, {3'h0, bus_base});
        $display("test bus read done");
    endtask : test_bus_read

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        cpu_req = '0;
        miscompares = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        test_reset();
        test_local();
        test_bus_write();
        test_bus_read();
        wrap_up();
    end

    // Watchdog: the tests take well under a thousand cycles
    initial begin
        #40000;
        miscompares++;
        wrap_up();
    end
endmodule : tb_ibuf_top
